// >>> inc/sebs_pkg.sv
// shared constants and types for the serial eeprom two-wire bus slave
package sebs_pkg;
	localparam int       ADDR_W       = 9;       // 512 bytes
	localparam int       MEM_BYTES    = 512;
	localparam int       PAGES        = 32;
	localparam int       PAGE_BYTES   = 16;
	localparam int       FIFO_DEPTH   = 32;
	localparam int       CLK_NS       = 100;     // 10 MHz system clock
	localparam int       PROG_TIME_US = 8000;    // longest erase/write time
	localparam int       PROG_CYCLES  = (PROG_TIME_US * 1000) / CLK_NS;
	localparam logic [3:0] DEV_CODE   = 4'h5;    // arbitrary device-type code
	localparam logic [3:0] BIT_ACK    = 4'h8;    // eight bits shifted
	localparam logic [3:0] BIT_END    = 4'h9;    // acknowledge clock seen
	localparam logic [3:0] BIT_ZERO   = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_CMD,
		ST_ADDR,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} sebs_state_t;

	// one buffered write: target address and byte
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} sebs_wr_t;
endpackage : sebs_pkg

// >>> verilog/sebs_slave.sv
// two-wire eeprom bus slave with write buffer and self-timed programming
`timescale 1ns/1ns

// write buffer: count based, flushable
module sebs_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 32
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	input  wire logic             i_flush,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push;
	logic             pop;

	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign push        = i_in_valid && o_in_ready;
	assign pop         = o_out_valid && i_out_ready;

	// storage has no reset; only pointers and fill level matter
	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= i_in_data;
		end
	end

	// pointers and fill level
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else if (i_flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : sebs_fifo

module sebs_slave #(
	parameter logic [3:0] DEV_CODE    = sebs_pkg::DEV_CODE,
	parameter int         PROG_CYCLES = sebs_pkg::PROG_CYCLES,
	parameter int         FIFO_DEPTH  = sebs_pkg::FIFO_DEPTH
) (
	input  wire logic        i_clock,
	input  wire logic        i_rst,
	input  wire logic        i_scl,
	input  wire logic        i_sda,
	input  wire logic        i_wp,
	input  wire logic [31:0] i_page_protect,
	output logic             o_sda_o,
	output logic             o_sda_oe,
	output logic             o_busy
);
	localparam int WW = $bits(sebs_pkg::sebs_wr_t);

	logic [7:0]              mem_arr [sebs_pkg::MEM_BYTES];
	logic                    scl_meta_reg, scl_s_reg, scl_d_reg;
	logic                    sda_meta_reg, sda_s_reg, sda_d_reg;
	logic                    wp_meta_reg, wp_s_reg;
	logic [31:0]             prot_meta_reg, prot_s_reg;
	sebs_pkg::sebs_state_t   state_reg, pend_reg, step_next;
	logic [3:0]              bit_cnt_reg;
	logic [7:0]              shift_reg, tx_reg;
	logic [8:0]              addr_reg;
	logic                    top_reg, wrote_reg, mack_reg;
	logic                    sda_oe_reg, sda_out_reg, busy_reg;
	logic [16:0]             prog_cnt_reg;
	logic                    scl_rise, scl_fall, start_det, stop_det;
	logic                    cmd_hit, write_end, fifo_flush;
	logic                    fifo_in_valid, fifo_in_ready, fifo_out_valid;
	sebs_pkg::sebs_wr_t      fifo_in, fifo_out;
	logic                    mem_we;
	logic [7:0]              rd_byte;

	// pins come from the master's domain: two flops before any use
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			scl_meta_reg  <= 1'b1;
			scl_s_reg     <= 1'b1;
			scl_d_reg     <= 1'b1;
			sda_meta_reg  <= 1'b1;
			sda_s_reg     <= 1'b1;
			sda_d_reg     <= 1'b1;
			wp_meta_reg   <= 1'b1;
			wp_s_reg      <= 1'b1;
			prot_meta_reg <= 32'hFFFFFFFF;
			prot_s_reg    <= 32'hFFFFFFFF;
		end else begin
			scl_meta_reg  <= i_scl;
			scl_s_reg     <= scl_meta_reg;
			scl_d_reg     <= scl_s_reg;
			sda_meta_reg  <= i_sda;
			sda_s_reg     <= sda_meta_reg;
			sda_d_reg     <= sda_s_reg;
			wp_meta_reg   <= i_wp;
			wp_s_reg      <= wp_meta_reg;
			prot_meta_reg <= i_page_protect;
			prot_s_reg    <= prot_meta_reg;
		end
	end

	// edge and condition detection on the synchronised lines
	assign scl_rise  = scl_s_reg && !scl_d_reg;
	assign scl_fall  = !scl_s_reg && scl_d_reg;
	assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
	assign stop_det  = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
	assign cmd_hit   = (shift_reg[7:4] == DEV_CODE) && !busy_reg;
	// bytes already taken still program when a refused byte ended the write
	assign write_end = stop_det && wrote_reg && (state_reg != sebs_pkg::ST_IDLE);
	// a write abandoned by start or plain stop must not be programmed later
	assign fifo_flush = (start_det || (stop_det && !write_end)) && !busy_reg;
	assign fifo_in_valid = scl_fall && (bit_cnt_reg == sebs_pkg::BIT_ACK)
		&& (state_reg == sebs_pkg::ST_WDATA) && !start_det && !stop_det;
	assign fifo_in.addr  = addr_reg;
	assign fifo_in.data  = shift_reg;
	assign rd_byte       = mem_arr[addr_reg];
	// a missing master acknowledge ends the read stream
	assign step_next = (state_reg == sebs_pkg::ST_RDATA && !mack_reg)
		? sebs_pkg::ST_IGNORE : pend_reg;

	// byte engine: slave only, every move follows a master clock edge, a start or a stop
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			state_reg   <= sebs_pkg::ST_IDLE;
			pend_reg    <= sebs_pkg::ST_IDLE;
			bit_cnt_reg <= sebs_pkg::BIT_ZERO;
			shift_reg   <= 8'h00;
			tx_reg      <= 8'h00;
			addr_reg    <= 9'h000;
			top_reg     <= 1'b0;
			wrote_reg   <= 1'b0;
			mack_reg    <= 1'b0;
			sda_oe_reg  <= 1'b0;
		end else if (start_det) begin
			state_reg   <= sebs_pkg::ST_CMD;
			bit_cnt_reg <= sebs_pkg::BIT_ZERO;
			wrote_reg   <= 1'b0;
			sda_oe_reg  <= 1'b0;
		end else if (stop_det) begin
			state_reg   <= sebs_pkg::ST_IDLE;
			bit_cnt_reg <= sebs_pkg::BIT_ZERO;
			sda_oe_reg  <= 1'b0;
		end else if (state_reg != sebs_pkg::ST_IDLE) begin
			if (scl_rise) begin
				// sample on the rising edge, msb first
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (bit_cnt_reg < sebs_pkg::BIT_ACK) begin
					shift_reg <= {shift_reg[6:0], sda_s_reg};
				end
				if (bit_cnt_reg == sebs_pkg::BIT_ACK) begin
					mack_reg <= !sda_s_reg;
				end
			end else if (scl_fall) begin
				if (bit_cnt_reg == sebs_pkg::BIT_ACK) begin
					// byte complete: decide acknowledge for the ninth clock
					sda_oe_reg <= 1'b0;
					unique case (state_reg)
						sebs_pkg::ST_CMD: begin
							if (cmd_hit) begin
								sda_oe_reg <= 1'b1;
								top_reg    <= shift_reg[1];
								pend_reg   <= shift_reg[0] ? sebs_pkg::ST_RDATA
									: sebs_pkg::ST_ADDR;
							end else begin
								pend_reg <= sebs_pkg::ST_IGNORE;
							end
						end
						sebs_pkg::ST_ADDR: begin
							sda_oe_reg <= 1'b1;
							addr_reg   <= {top_reg, shift_reg};
							pend_reg   <= sebs_pkg::ST_WDATA;
						end
						sebs_pkg::ST_WDATA: begin
							// full buffer refuses the byte by withholding the ack
							if (fifo_in_ready) begin
								sda_oe_reg <= 1'b1;
								addr_reg   <= {addr_reg[8:4], addr_reg[3:0] + 4'h1};
								wrote_reg  <= 1'b1;
								pend_reg   <= sebs_pkg::ST_WDATA;
							end else begin
								pend_reg <= sebs_pkg::ST_IGNORE;
							end
						end
						sebs_pkg::ST_RDATA:  pend_reg <= sebs_pkg::ST_RDATA;
						sebs_pkg::ST_IGNORE: pend_reg <= sebs_pkg::ST_IGNORE;
						sebs_pkg::ST_IDLE:   pend_reg <= sebs_pkg::ST_IDLE;
					endcase
				end else if (bit_cnt_reg == sebs_pkg::BIT_END) begin
					// end of ninth clock: release, move on, maybe start a byte
					bit_cnt_reg <= sebs_pkg::BIT_ZERO;
					state_reg   <= step_next;
					if (step_next == sebs_pkg::ST_RDATA) begin
						tx_reg     <= rd_byte;
						sda_oe_reg <= !rd_byte[7];
						addr_reg   <= addr_reg + 9'h001;
					end else begin
						sda_oe_reg <= 1'b0;
					end
				end else if (state_reg == sebs_pkg::ST_RDATA) begin
					sda_oe_reg <= !tx_reg[3'(4'h7 - bit_cnt_reg)];
				end
			end
		end
	end

	// open drain: data output is a constant low, only the enable moves
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			sda_out_reg <= 1'b0;
		end else begin
			sda_out_reg <= 1'b0;
		end
	end

	// programming timer; stop after written data starts it
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			busy_reg     <= 1'b0;
			prog_cnt_reg <= 17'h00000;
		end else if (write_end && !busy_reg) begin
			busy_reg     <= 1'b1;
			prog_cnt_reg <= 17'(PROG_CYCLES - 1);
		end else if (busy_reg) begin
			if (prog_cnt_reg != 17'h00000) begin
				prog_cnt_reg <= prog_cnt_reg - 17'h00001;
			end else if (!fifo_out_valid) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// buffer drains only while programming, so page bytes pile up before
	sebs_fifo #(
		.WIDTH (WW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rst       (i_rst),
		.i_flush     (fifo_flush),
		.i_in_valid  (fifo_in_valid),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (fifo_in),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (busy_reg),
		.o_out_data  (fifo_out)
	);

	// array write gated by the protect pin and the page's own bit
	assign mem_we = busy_reg && fifo_out_valid && !wp_s_reg
		&& !prot_s_reg[fifo_out.addr[8:4]];

	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			mem_arr[fifo_out.addr] <= fifo_out.data;
		end
	end

	assign o_sda_o  = sda_out_reg;
	assign o_sda_oe = sda_oe_reg;
	assign o_busy   = busy_reg;

	chk_oe_on_fall: assert property (@(posedge i_clock) disable iff (i_rst)
		$changed(sda_oe_reg) |-> ($past(scl_fall) || $past(start_det) || $past(stop_det)))
		else $error("data enable moved away from a clock fall");
	chk_drive_low: assert property (@(posedge i_clock) disable iff (i_rst)
		o_sda_oe |-> (o_sda_o == 1'b0))
		else $error("data line driven high");
	chk_busy_nak: assert property (@(posedge i_clock) disable iff (i_rst)
		(busy_reg && state_reg == sebs_pkg::ST_CMD && scl_fall
		&& bit_cnt_reg == sebs_pkg::BIT_ACK && !start_det && !stop_det) |=> !sda_oe_reg)
		else $error("command acknowledged while programming");
	chk_wp_block: assert property (@(posedge i_clock) disable iff (i_rst)
		mem_we |-> !wp_s_reg)
		else $error("array written under write protect");
	chk_page_block: assert property (@(posedge i_clock) disable iff (i_rst)
		mem_we |-> !prot_s_reg[fifo_out.addr[8:4]])
		else $error("protected page written");
	chk_start_cmd: assert property (@(posedge i_clock) disable iff (i_rst)
		start_det |=> (state_reg == sebs_pkg::ST_CMD && bit_cnt_reg == 4'h0 && !sda_oe_reg))
		else $error("start did not restart command");
	chk_read_stop: assert property (@(posedge i_clock) disable iff (i_rst)
		(stop_det && !wrote_reg && !busy_reg)
		|=> (state_reg == sebs_pkg::ST_IDLE && !busy_reg))
		else $error("stop after read started programming");
	chk_write_prog: assert property (@(posedge i_clock) disable iff (i_rst)
		(write_end && !busy_reg) |=> busy_reg [*2])
		else $error("stop after write did not program");
	chk_page_fixed: assert property (@(posedge i_clock) disable iff (i_rst)
		(fifo_in_valid && fifo_in_ready)
		|=> (addr_reg[8:4] == $past(addr_reg[8:4])
		&& addr_reg[3:0] == $past(addr_reg[3:0]) + 4'h1))
		else $error("page write left its page");
	chk_prog_done: assert property (@(posedge i_clock) disable iff (i_rst)
		$fell(busy_reg) |-> ($past(prog_cnt_reg) == 17'h00000 && !$past(fifo_out_valid)))
		else $error("programming ended early");
endmodule : sebs_slave

// >>> tb/sebs_master.sv
// two-wire bus master model that drives clock and data toward the slave
`timescale 1ns/1ns
module sebs_master (
	input  wire logic i_clock,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda
);
	// bus idles with clock high and data released to the pull-up
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clock);
	endtask : wait_n

	// one pulse: data moves mid-low, read back mid-high, 800 ns period
	task automatic bit_io(input logic b, output logic r);
		wait_n(2);
		o_sda = b;
		wait_n(2);
		o_scl = 1'b1;
		wait_n(2);
		r = i_sda;
		wait_n(2);
		o_scl = 1'b0;
	endtask : bit_io

	// data falls while clock high; also used as a repeated start
	task automatic start();
		wait_n(2);
		o_sda = 1'b1;
		wait_n(2);
		o_scl = 1'b1;
		wait_n(4);
		o_sda = 1'b0;
		wait_n(4);
		o_scl = 1'b0;
	endtask : start

	// data rises while clock high; clock then stands still high
	task automatic stop();
		wait_n(2);
		o_sda = 1'b0;
		wait_n(2);
		o_scl = 1'b1;
		wait_n(4);
		o_sda = 1'b1;
		wait_n(4);
	endtask : stop

	// send a byte msb first, release data for the slave's acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : wbyte

	// take a byte, then acknowledge it or leave the line released
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask : rbyte
endmodule : sebs_master

// >>> tb/sebs_slave_tb.sv
// self-checking bench for the two-wire eeprom bus slave
`timescale 1ns/1ns
module sebs_slave_tb;
	localparam logic [3:0] DEV = sebs_pkg::DEV_CODE;
	logic        i_clock        = 1'b0;
	logic        i_rst          = 1'b1;
	logic        i_wp           = 1'b0;
	logic [31:0] i_page_protect = 32'h0;
	logic        m_scl;
	logic        m_sda;
	logic        o_sda_o;
	logic        o_sda_oe;
	logic        o_busy;
	logic        oe_q           = 1'b0;
	logic        ak;
	int          n_errors       = 0;
	int          cmp_count      = 0;
	int          cyc            = 0;
	int          hi_cnt         = 0;
	wire         sda_line       = m_sda & ~o_sda_oe; // wired-and with pull-up

	sebs_master sebs_master_inst (.i_clock(i_clock), .i_sda(sda_line), .o_scl(m_scl),
		.o_sda(m_sda));
	// short programming time keeps the run brief yet outlasts one polled command
	sebs_slave #(.PROG_CYCLES(200)) sebs_slave_inst (.i_clock(i_clock), .i_rst(i_rst),
		.i_scl(m_scl), .i_sda(sda_line), .i_wp(i_wp), .i_page_protect(i_page_protect),
		.o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_busy(o_busy));

	// 10 MHz system clock
	always #50 i_clock = ~i_clock;

	task automatic results();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : results

	task automatic chk1(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk1

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk8

	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clock);
	endtask : wait_n

	// bounded wait for programming to finish
	task automatic wait_idle();
		int k = 0;
		while (o_busy !== 1'b0 && k < 1000) begin
			wait_n(1);
			k++;
		end
		chk1(o_busy, 1'b0);
	endtask : wait_idle

	// write command with the ignored bits set, then low address byte
	task automatic cmd_addr(input logic [8:0] a);
		sebs_master_inst.start();
		sebs_master_inst.wbyte({DEV, 2'b11, a[8], 1'b0}, ak);
		chk1(ak, 1'b1);
		sebs_master_inst.wbyte(a[7:0], ak);
		chk1(ak, 1'b1);
	endtask : cmd_addr

	// single byte write; programming must start at the stop
	task automatic wr1(input logic [8:0] a, input logic [7:0] d);
		cmd_addr(a);
		sebs_master_inst.wbyte(d, ak);
		chk1(ak, 1'b1);
		sebs_master_inst.stop();
		wait_n(2);
		chk1(o_busy, 1'b1);
	endtask : wr1

	// random read of one or two bytes, ended by a missing acknowledge
	task automatic rdchk(input logic [8:0] a, input logic [7:0] e0, input logic two,
		input logic [7:0] e1);
		logic [7:0] d;
		cmd_addr(a);
		sebs_master_inst.start();
		sebs_master_inst.wbyte({DEV, 4'h1}, ak);
		chk1(ak, 1'b1);
		sebs_master_inst.rbyte(two, d);
		chk8(d, e0);
		if (two) begin
			sebs_master_inst.rbyte(1'b0, d);
			chk8(d, e1);
		end
		sebs_master_inst.stop();
		wait_n(4);
		chk1(o_busy, 1'b0);
	endtask : rdchk

	// device output must hold still once the clock is well into its high phase
	always @(negedge i_clock) begin
		hi_cnt = m_scl ? hi_cnt + 1 : 0;
		if (hi_cnt > 2)
			chk1(o_sda_oe, oe_q);
		if (o_sda_oe === 1'b1)
			chk1(o_sda_o, 1'b0);
		oe_q = o_sda_oe;
	end

	// cycle ceiling cuts a hang short
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			n_errors++;
			results();
		end
	end

	// main sequence
	initial begin
		wait_n(5);
		i_rst = 1'b0;
		wait_n(3);
		wr1(9'h1A5, 8'h3C);
		sebs_master_inst.start();
		sebs_master_inst.wbyte({DEV, 4'h0}, ak);
		chk1(ak, 1'b0);
		sebs_master_inst.stop();
		wait_idle();
		rdchk(9'h1A5, 8'h3C, 1'b0, 8'h00);
		// foreign device-type code is not answered
		sebs_master_inst.start();
		sebs_master_inst.wbyte({~DEV, 4'h0}, ak);
		chk1(ak, 1'b0);
		sebs_master_inst.stop();
		// page write from the last byte of a page wraps inside it
		cmd_addr(9'h02F);
		for (int i = 0; i < 3; i++) begin
			sebs_master_inst.wbyte(8'(8'hA0 + i), ak);
			chk1(ak, 1'b1);
		end
		sebs_master_inst.stop();
		wait_idle();
		rdchk(9'h020, 8'hA1, 1'b1, 8'hA2);
		rdchk(9'h02F, 8'hA0, 1'b0, 8'h00);
		// write-protect pin and page protection bit block changes
		i_wp = 1'b1;
		wr1(9'h020, 8'hEE);
		wait_idle();
		i_wp = 1'b0;
		rdchk(9'h020, 8'hA1, 1'b0, 8'h00);
		i_page_protect = 32'h4;
		wr1(9'h021, 8'hDD);
		wait_idle();
		i_page_protect = 32'h0;
		rdchk(9'h021, 8'hA2, 1'b0, 8'h00);
		// sequential read rolls over from the top address
		wr1(9'h1FF, 8'h5A);
		wait_idle();
		wr1(9'h000, 8'hC3);
		wait_idle();
		rdchk(9'h1FF, 8'h5A, 1'b1, 8'hC3);
		// start in the middle of a data byte abandons it
		cmd_addr(9'h060);
		for (int i = 0; i < 4; i++) begin
			sebs_master_inst.bit_io(1'b0, ak);
		end
		wr1(9'h061, 8'h77);
		wait_idle();
		rdchk(9'h061, 8'h77, 1'b0, 8'h00);
		// write buffer refuses the byte after it fills
		cmd_addr(9'h070);
		for (int i = 0; i < 33; i++) begin
			sebs_master_inst.wbyte(8'(8'h80 + i), ak);
			chk1(ak, i < 32);
		end
		sebs_master_inst.stop();
		wait_idle();
		rdchk(9'h070, 8'h90, 1'b1, 8'h91);
		results();
	end
endmodule : sebs_slave_tb
